/* File: inc/ipcfg_pkg.sv */
// Purpose: shared constants and types for the interrupt priority configuration block
// Assumes: 32-bit register bus, byte addresses, one register per aligned word
// Notes:   every offset, field position, reset value and width is named here once
package ipcfg_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int unsigned LEVEL_W    = 3;   // one priority level field
  localparam int unsigned FIELDS_PER = 4;   // level fields per priority register
  localparam int unsigned IPR_COUNT  = 10;  // priority registers A-C, E-I, K, L
  localparam int unsigned ADDR_W     = 6;   // byte address width
  localparam int unsigned DATA_W     = 32;  // bus data width
  localparam int unsigned IPR_W      = 16;  // priority register width

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CPU_CTRL = 6'h00;  // cpu_priority_ctrl
  localparam logic [ADDR_W-1:0] OFS_IPR_A    = 6'h04;  // irq_priority_a
  localparam logic [ADDR_W-1:0] OFS_IPR_B    = 6'h08;  // irq_priority_b
  localparam logic [ADDR_W-1:0] OFS_IPR_C    = 6'h0C;  // irq_priority_c
  localparam logic [ADDR_W-1:0] OFS_IPR_E    = 6'h10;  // irq_priority_e
  localparam logic [ADDR_W-1:0] OFS_IPR_F    = 6'h14;  // irq_priority_f
  localparam logic [ADDR_W-1:0] OFS_IPR_G    = 6'h18;  // irq_priority_g
  localparam logic [ADDR_W-1:0] OFS_IPR_H    = 6'h1C;  // irq_priority_h
  localparam logic [ADDR_W-1:0] OFS_IPR_I    = 6'h20;  // irq_priority_i
  localparam logic [ADDR_W-1:0] OFS_IPR_K    = 6'h24;  // irq_priority_k
  localparam logic [ADDR_W-1:0] OFS_IPR_L    = 6'h28;  // irq_priority_l

  // priority register offsets in register order
  localparam logic [IPR_COUNT-1:0][ADDR_W-1:0] IPR_OFFSETS = {
    OFS_IPR_L, OFS_IPR_K, OFS_IPR_I, OFS_IPR_H, OFS_IPR_G,
    OFS_IPR_F, OFS_IPR_E, OFS_IPR_C, OFS_IPR_B, OFS_IPR_A};

  // ---------------------------------------------------------------
  // cpu_priority_ctrl fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT    = 7;  // cpu_prio_ctrl_enable
  localparam int unsigned XFER_LVL_LSB   = 4;  // transfer engine level field
  localparam int unsigned AUTO_SET_BIT   = 3;  // auto_level_set_enable
  localparam int unsigned CPU_LVL_LSB    = 0;  // cpu_level_field
  localparam logic [7:0]  CPU_CTRL_RESET = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_LOWEST = 3'h0;

  // ---------------------------------------------------------------
  // irq_priority_reg fields: level_field_0..3 at bits 2:0, 6:4, 10:8, 14:12
  // ---------------------------------------------------------------
  localparam int unsigned FIELD_STRIDE = 4;   // lsb of field n is n * stride
  localparam logic [LEVEL_W-1:0] IPR_FIELD_RESET = 3'h7;

  // four level fields of one priority register
  typedef logic [FIELDS_PER-1:0][LEVEL_W-1:0] ipcfg_levels_t;

endpackage

/* File: inc/ipcfg_wr_if.sv */
// Purpose: write port and read back of one priority register
// Assumes: driven by the register decode in the top module
// Notes:   one instance per priority register
interface ipcfg_wr_if;
  import ipcfg_pkg::*;

  logic                 wrEn;    // one-cycle write commit
  logic [1:0]           byteEn;  // low two byte lanes of the bus
  logic [IPR_W-1:0]     wrData;  // low half of the bus write data
  ipcfg_levels_t        levels;  // current level fields
  logic [IPR_W-1:0]     rdData;  // read image, reserved bits zero

  // decode side
  modport ctrl (output wrEn, output byteEn, output wrData, input levels, input rdData);
  // register side
  modport regs (input wrEn, input byteEn, input wrData, output levels, output rdData);
endinterface

/* File: hw/ipcfg_prio_reg.sv */
// Purpose: one priority register holding four 3-bit level fields
// Assumes: wrEn is a single-cycle commit from the bus decode
// Notes:   reserved bits 15, 11, 7 and 3 hold no storage
module ipcfg_prio_reg
  import ipcfg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  ipcfg_wr_if.regs  port
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ipcfg_levels_t level;  // four level fields
  } ipcfg_preg_t;

  ipcfg_preg_t state_reg;   // registered state
  ipcfg_preg_t state_next;  // next state

  // byte lane update of each field, reserved bits dropped
  always_comb begin
    state_next = state_reg;
    if (port.wrEn) begin
      for (int f = 0; f < FIELDS_PER; f++) begin
        // fields 0,1 sit in byte 0, fields 2,3 in byte 1
        if (port.byteEn[f/2]) begin
          state_next.level[f] = port.wrData[f*FIELD_STRIDE +: LEVEL_W];
        end
      end
    end
  end

  // every field starts at level 7
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= {FIELDS_PER{IPR_FIELD_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // read image and continuous level output
  always_comb begin
    port.rdData = '0;
    for (int f = 0; f < FIELDS_PER; f++) begin
      port.rdData[f*FIELD_STRIDE +: LEVEL_W] = state_reg.level[f];
    end
  end
  assign port.levels = state_reg.level;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_reset_all_seven: assert property (@(posedge clk_sys) !rstn ##1 !rstn |->
    state_reg.level == {FIELDS_PER{IPR_FIELD_RESET}})
    else $error("priority fields not at level 7 in reset");
  chk_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    (port.rdData & 16'h8888) == 16'h0000)
    else $error("reserved priority bits read nonzero");
  chk_field_write_lane: assert property (@(posedge clk_sys) disable iff (!rstn)
    port.wrEn && port.byteEn[0] |=> port.levels[0] == $past(port.wrData[2:0]))
    else $error("level field 0 did not take written value");
  chk_hold_without_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    !port.wrEn |=> $stable(port.levels))
    else $error("priority fields changed without a write");

endmodule

/* File: hw/ipcfg_top.sv */
// Purpose: cpu priority control and ten interrupt priority registers
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 32-bit data
// Notes:   each access answers two edges after the request is raised
//          read data is captured one edge before a write would commit
//          unmapped words read zero and drop writes
//          no level field exists for the non-maskable source
//          while auto set is on the cpu level follows the core mask
//
// The Avalon-MM register port and the address map were left to the implementer.
module ipcfg_top
  import ipcfg_pkg::*;
(
  input  wire logic                                      clk_sys,
  input  wire logic                                      rstn,
  // register bus
  input  wire logic [ipcfg_pkg::ADDR_W-1:0]              avs_address,
  input  wire logic                                      avs_read,
  input  wire logic                                      avs_write,
  input  wire logic [ipcfg_pkg::DATA_W-1:0]              avs_writedata,
  input  wire logic [3:0]                                avs_byteenable,
  output logic      [ipcfg_pkg::DATA_W-1:0]              avs_readdata,
  output logic                                           avs_waitrequest,
  // cpu interrupt mask from the core
  input  wire logic                                      condCodeMask,
  input  wire logic [ipcfg_pkg::LEVEL_W-1:0]             extCtrlMask,
  input  wire logic                                      extMaskMode,
  // to arbitration
  output logic                                           cpuPrioActive,
  output logic      [ipcfg_pkg::LEVEL_W-1:0]             cpuArbLevel,
  output logic      [ipcfg_pkg::LEVEL_W-1:0]             xferArbLevel,
  output ipcfg_pkg::ipcfg_levels_t [ipcfg_pkg::IPR_COUNT-1:0] irqLevels
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic               waitReq;     // bus wait, low for the answer cycle
    logic [DATA_W-1:0]  rdData;      // captured read data
    logic               ctrlEn;      // cpu_prio_ctrl_enable
    logic [LEVEL_W-1:0] xferLevel;   // transfer engine level
    logic               autoEn;      // auto_level_set_enable
    logic [LEVEL_W-1:0] cpuLevel;    // cpu_level_field
    logic               prioActive;  // registered copy of ctrlEn for output
    logic [LEVEL_W-1:0] arbLevel;    // effective cpu level for arbitration
  } ipcfg_top_t;

  ipcfg_top_t state_reg;   // registered state
  ipcfg_top_t state_next;  // next state

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic                 busReq;      // read or write pending
  logic                 commit;      // access completes at this edge
  logic                 hitCtrl;     // address is the cpu control register
  logic [IPR_COUNT-1:0] hitIpr;      // one-hot priority register hit
  logic [LEVEL_W-1:0]   maskLevel;   // cpu mask as a level
  logic [7:0]           ctrlImage;   // cpu control read image
  logic [IPR_COUNT-1:0][IPR_W-1:0] iprRead;  // priority register read images
  logic                 anyHit;      // address hits a mapped register

  // a request is pending while read or write is high
  assign busReq = avs_read | avs_write;
  // the access completes at the edge where wait is already low
  assign commit = busReq & ~state_reg.waitReq;
  // word compare; the two low address bits are ignored
  assign hitCtrl = (avs_address[ADDR_W-1:2] == OFS_CPU_CTRL[ADDR_W-1:2]);
  // unmapped words read zero and ignore writes
  assign anyHit = hitCtrl | (|hitIpr);

  // one-hot compare against each priority register offset
  always_comb begin
    for (int r = 0; r < IPR_COUNT; r++) begin
      hitIpr[r] = (avs_address[ADDR_W-1:2] == IPR_OFFSETS[r][ADDR_W-1:2]);
    end
  end

  // ---------------------------------------------------------------
  // cpu interrupt mask
  // ---------------------------------------------------------------
  // single mask bit fills all three level bits; extended mask copies as is
  // the core tells through extMaskMode which of its masks is live
  always_comb begin
    if (extMaskMode) begin
      maskLevel = extCtrlMask;
    end else begin
      maskLevel = {LEVEL_W{condCodeMask}};
    end
  end

  // ---------------------------------------------------------------
  // read images
  // ---------------------------------------------------------------
  // cpu control register read image, unused bits from the reset value
  always_comb begin
    ctrlImage = CPU_CTRL_RESET;
    ctrlImage[CTRL_EN_BIT] = state_reg.ctrlEn;
    ctrlImage[XFER_LVL_LSB +: LEVEL_W] = state_reg.xferLevel;
    ctrlImage[AUTO_SET_BIT] = state_reg.autoEn;
    ctrlImage[CPU_LVL_LSB +: LEVEL_W] = state_reg.cpuLevel;
  end

  // ---------------------------------------------------------------
  // priority registers, maskable sources only
  // ---------------------------------------------------------------
  for (genvar g = 0; g < IPR_COUNT; g++) begin : gen_ipr
    ipcfg_wr_if wrBus();  // write port of this register

    // write commits one cycle per accepted bus write
    assign wrBus.wrEn   = commit & avs_write & hitIpr[g];
    // lanes 2 and 3 carry no priority bits
    assign wrBus.byteEn = avs_byteenable[1:0];
    assign wrBus.wrData = avs_writedata[IPR_W-1:0];
    // reserved bits are already zero in the read image
    assign iprRead[g]   = wrBus.rdData;

    // the level fields drive arbitration straight from their flops
    assign irqLevels[g] = wrBus.levels;

    // field storage; no field exists for the non-maskable source
    ipcfg_prio_reg ipcfg_prio_reg_i (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .port    (wrBus.regs)
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    // every field holds unless a branch below changes it
    state_next = state_reg;

    // bus handshake: wait drops for exactly one cycle per request
    // a read of an unmapped word leaves the cleared data in place
    if (busReq && state_reg.waitReq) begin
      state_next.waitReq = 1'b0;
      state_next.rdData  = '0;
      // read image captured one edge before the answer
      if (avs_read) begin
        if (hitCtrl) begin
          state_next.rdData[7:0] = ctrlImage;
        end else begin
          for (int r = 0; r < IPR_COUNT; r++) begin
            if (hitIpr[r]) begin
              state_next.rdData[IPR_W-1:0] = iprRead[r];
            end
          end
        end
      end
    end else begin
      // answer given or no request: back to waiting
      state_next.waitReq = 1'b1;
    end

    // cpu control write, low byte lane only
    if (commit && avs_write && hitCtrl && avs_byteenable[0]) begin
      state_next.ctrlEn    = avs_writedata[CTRL_EN_BIT];
      state_next.xferLevel = avs_writedata[XFER_LVL_LSB +: LEVEL_W];
      state_next.autoEn    = avs_writedata[AUTO_SET_BIT];
      // level field only writable while auto set is off
      if (!state_reg.autoEn) begin
        state_next.cpuLevel = avs_writedata[CPU_LVL_LSB +: LEVEL_W];
      end
    end

    // auto set overrides the level field every cycle
    if (state_reg.autoEn) begin
      state_next.cpuLevel = maskLevel;
    end

    // effective cpu priority toward the transfer engines
    // taken from the next state so outputs move with the control register
    state_next.prioActive = state_next.ctrlEn;
    if (state_next.ctrlEn) begin
      state_next.arbLevel = state_next.cpuLevel;
    end else begin
      state_next.arbLevel = LEVEL_LOWEST;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // wait high and every field at its reset value
      state_reg.waitReq    <= 1'b1;
      state_reg.rdData     <= '0;
      state_reg.ctrlEn     <= CPU_CTRL_RESET[CTRL_EN_BIT];
      state_reg.xferLevel  <= CPU_CTRL_RESET[XFER_LVL_LSB +: LEVEL_W];
      state_reg.autoEn     <= CPU_CTRL_RESET[AUTO_SET_BIT];
      state_reg.cpuLevel   <= CPU_CTRL_RESET[CPU_LVL_LSB +: LEVEL_W];
      state_reg.prioActive <= 1'b0;
      state_reg.arbLevel   <= LEVEL_LOWEST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  // no logic stands between these flops and the pins
  assign avs_waitrequest = state_reg.waitReq;
  assign avs_readdata    = state_reg.rdData;
  assign cpuPrioActive   = state_reg.prioActive;
  assign cpuArbLevel     = state_reg.arbLevel;
  assign xferArbLevel    = state_reg.xferLevel;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // checked from the second edge in reset, flops start unknown
  chk_reset_cpu_zero: assert property (@(posedge clk_sys) !rstn ##1 !rstn |->
    state_reg.cpuLevel == 3'h0 && cpuArbLevel == 3'h0)
    else $error("cpu level not zero in reset");
  // enable and automatic set
  chk_enabled_follows_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg.ctrlEn |-> cpuPrioActive && cpuArbLevel == state_reg.cpuLevel)
    else $error("cpu arbitration level does not follow level field");
  chk_auto_blocks_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitCtrl && state_reg.autoEn
    |=> state_reg.cpuLevel == $past(maskLevel))
    else $error("level field written while auto set enabled");
  chk_disabled_lowest: assert property (@(posedge clk_sys) disable iff (!rstn)
    !state_reg.ctrlEn |-> !cpuPrioActive && cpuArbLevel == 3'h0)
    else $error("cpu not lowest while control disabled");
  chk_auto_copy_mask: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg.autoEn && !extMaskMode && condCodeMask |=> state_reg.cpuLevel == 3'h7)
    else $error("single mask bit not reflected as level 7");

  // bus handshake and priority register writes
  chk_bus_answer_two: assert property (@(posedge clk_sys) disable iff (!rstn)
    busReq && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle after request");
  chk_ipr_write_visible: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitIpr[0] && avs_byteenable[1]
    |=> irqLevels[0][3] == $past(avs_writedata[14:12]))
    else $error("priority register A field 3 not visible after write");
  // lane off leaves the field alone
  chk_ipr_lane_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitIpr[0] && !avs_byteenable[1]
    |=> irqLevels[0][3] == $past(irqLevels[0][3]))
    else $error("priority register A field 3 changed with its lane off");

  // read answers: reserved and upper bits zero, unmapped words all zero
  chk_read_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_read && !hitCtrl |-> (avs_readdata & 32'hFFFF_8888) == 32'h0000_0000)
    else $error("reserved or upper read bits nonzero");
  chk_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_read && !anyHit |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped word read nonzero");
  chk_ctrl_read_image: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_read && hitCtrl && !state_reg.autoEn
    |-> avs_readdata == {24'h00_0000, ctrlImage})
    else $error("cpu control read data differs from register");

  // cpu control writes and idle bus wait
  chk_manual_level_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitCtrl && avs_byteenable[0] && !state_reg.autoEn
    |=> state_reg.cpuLevel == $past(avs_writedata[2:0]))
    else $error("level field did not take written value");
  chk_xfer_level_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitCtrl && avs_byteenable[0]
    |=> xferArbLevel == $past(avs_writedata[6:4]))
    else $error("transfer engine level did not take written value");
  chk_lane_off_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitCtrl && !avs_byteenable[0]
    |=> $stable(state_reg.ctrlEn) && $stable(state_reg.xferLevel) && $stable(state_reg.autoEn))
    else $error("cpu control changed with its lane off");
  chk_wait_idle_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    !busReq |=> avs_waitrequest)
    else $error("wait low without a request");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  cov_auto_mode: cover property (@(posedge clk_sys) disable iff (!rstn)
    state_reg.autoEn && extMaskMode && state_reg.ctrlEn);
  cov_ipr_write: cover property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitIpr[IPR_COUNT-1]);
  cov_ctrl_read: cover property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_read && hitCtrl && cpuArbLevel == 3'h7);
  cov_ccr_auto: cover property (@(posedge clk_sys) disable iff (!rstn)
    state_reg.autoEn && !extMaskMode && condCodeMask);
  cov_lane_off: cover property (@(posedge clk_sys) disable iff (!rstn)
    commit && avs_write && hitCtrl && !avs_byteenable[0]);

endmodule

/* File: sim/ipcfg_core_model.sv */
// Purpose: behavioural processor core presenting its interrupt mask
// Assumes: the bench tells the core when its mask changes
// Notes:   mask changes land on a clock edge, as the core would update them
module ipcfg_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       reqMode,       // wanted mask mode
  input  wire logic       reqCcr,        // wanted single mask bit
  input  wire logic [2:0] reqExt,        // wanted extended mask
  output logic            condCodeMask,
  output logic [2:0]      extCtrlMask,
  output logic            extMaskMode
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // mask registers of the core
  // -------------------------------------------------------------
  // all masks clear while the core is in reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      condCodeMask <= 1'b0;
      extCtrlMask  <= 3'h0;
      extMaskMode  <= 1'b0;
    end else begin
      condCodeMask <= reqCcr;
      extCtrlMask  <= reqExt;
      extMaskMode  <= reqMode;
    end
  end
endmodule

/* File: sim/ipcfg_top_test.sv */
// Purpose: self-checking bench for the priority configuration block
// Assumes: read results queued by the driver, compared by a watcher
// Notes:   one idle cycle between bus accesses keeps drivers race free
module ipcfg_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ipcfg_pkg::*;
  typedef struct { string name; logic [31:0] val; } ipcfg_exp_t;
  logic                          clk_sys = 1'b0;
  logic                          rstn = 1'b0;
  logic [ADDR_W-1:0]             avsAddr = '0;
  logic                          avsRead = 1'b0, avsWrite = 1'b0;
  logic [31:0]                   avsWdata = '0, avsRdata;
  logic [3:0]                    avsBe = '0;
  logic                          avsWait, ccm, emm, cpa;
  logic [2:0]                    ecm, cal, xal;
  logic                          reqMode = 1'b0, reqCcr = 1'b0;
  logic [2:0]                    reqExt = 3'h0;
  ipcfg_levels_t [IPR_COUNT-1:0] lv;
  logic [15:0]                   iprModel [IPR_COUNT];  // expected register images
  ipcfg_exp_t                    expq [$];              // pending read results
  ipcfg_exp_t                    note;                  // oldest note taken off
  int                            mismatches = 0, checkCount = 0, cycles = 0;
  logic [31:0]                   seed, d;
  logic [3:0]                    b;
  // -------------------------------------------------------------
  // clock, design and core
  // -------------------------------------------------------------
  always #25 clk_sys = !clk_sys;
  ipcfg_top ipcfg_top_i (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
    .avs_byteenable(avsBe), .avs_readdata(avsRdata), .avs_waitrequest(avsWait),
    .condCodeMask(ccm), .extCtrlMask(ecm), .extMaskMode(emm), .cpuPrioActive(cpa),
    .cpuArbLevel(cal), .xferArbLevel(xal), .irqLevels(lv));
  ipcfg_core_model ipcfg_core_model_i (.clk_sys(clk_sys), .rstn(rstn), .reqMode(reqMode),
    .reqCcr(reqCcr), .reqExt(reqExt), .condCodeMask(ccm), .extCtrlMask(ecm),
    .extMaskMode(emm));
  // -------------------------------------------------------------
  // checking and closing
  // -------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // watcher: a read answer is compared with the oldest note
  // sampled at the rising edge at which the master takes the answer
  always @(posedge clk_sys) begin
    if (rstn && avsRead && avsWait === 1'b0) begin
      if (expq.size() == 0) check("unexpected read", avsRdata, 32'hFFFF_FFFF);
      else begin
        note = expq.pop_front();
        check(note.name, avsRdata, note.val);
      end
    end
  end
  // -------------------------------------------------------------
  // bus master tasks
  // -------------------------------------------------------------
  // hold the request until waitrequest is sampled low, then release
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] wd,
                     input logic [3:0] be);
    logic done;
    done = 1'b0;
    avsAddr  <= a;
    avsRead  <= !w;
    avsWrite <= w;
    avsWdata <= wd;
    avsBe    <= be;
    while (!done) begin
      @(posedge clk_sys);
      done = (avsWait === 1'b0);
    end
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input string n, input logic [5:0] a, input logic [31:0] e);
    expq.push_back('{n, e});
    bus(a, 1'b0, '0, 4'h0);
  endtask
  // write one priority register and track its image
  task automatic wr_ipr(input int r, input logic [31:0] wd, input logic [3:0] be);
    if (be[0]) iprModel[r][7:0] = wd[7:0];
    if (be[1]) iprModel[r][15:8] = wd[15:8];
    iprModel[r] &= 16'h7777;
    bus(IPR_OFFSETS[r], 1'b1, wd, be);
    check("irq levels", 32'({lv[r][3], lv[r][2], lv[r][1], lv[r][0]}),
          32'({iprModel[r][14:12], iprModel[r][10:8], iprModel[r][6:4], iprModel[r][2:0]}));
    rd("priority reg", IPR_OFFSETS[r], 32'(iprModel[r]));
  endtask
  task automatic reset_checks();
    check("cpu active", 32'(cpa), 32'h0);
    check("cpu level", 32'(cal), 32'h0);
    rd("cpu ctrl", OFS_CPU_CTRL, 32'h0);
    for (int r = 0; r < IPR_COUNT; r++) begin
      iprModel[r] = 16'h7777;
      check("reset levels", 32'(lv[r]), 32'hFFF);
      rd("reset prio", IPR_OFFSETS[r], 32'h7777);
    end
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    seed = 32'h18F2_72B8;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    reset_checks();
    // every level value in every field of priority register B, reserved bits written as one
    for (int v = 0; v < 8; v++) wr_ipr(1, {16'h0, {4{1'b1, 3'(v)}}}, 4'hF);
    // random data and lanes on all registers
    repeat (3) for (int r = 0; r < IPR_COUNT; r++) begin
      d = $random(seed);
      b = 4'($random(seed));
      wr_ipr(r, d, b);
    end
    // unmapped place: write dropped, reads zero
    bus(6'h2C, 1'b1, 32'hFFFF_FFFF, 4'hF);
    rd("unmapped", 6'h2C, 32'h0);
    rd("after unmapped", OFS_IPR_A, 32'(iprModel[0]));
    // enable clear: cpu stays lowest whatever its level
    bus(OFS_CPU_CTRL, 1'b1, 32'h25, 4'h1);
    check("cpu level off", 32'(cal), 32'h0);
    check("xfer level", 32'(xal), 32'h2);
    bus(OFS_CPU_CTRL, 1'b1, 32'hA5, 4'h0);
    rd("ctrl lane off", OFS_CPU_CTRL, 32'h25);
    bus(OFS_CPU_CTRL, 1'b1, 32'hA5, 4'h1);
    check("cpu level on", 32'(cal), 32'h5);
    check("cpu active on", 32'(cpa), 32'h1);
    // automatic set from the extended mask, writes to level ignored
    reqMode <= 1'b1;
    reqExt  <= 3'h3;
    bus(OFS_CPU_CTRL, 1'b1, 32'hB8, 4'h1);
    repeat (2) @(posedge clk_sys);
    check("auto ext", 32'(cal), 32'h3);
    bus(OFS_CPU_CTRL, 1'b1, 32'hBE, 4'h1);
    rd("auto ignores", OFS_CPU_CTRL, 32'hBB);
    // single mask bit maps to the top or bottom level
    reqMode <= 1'b0;
    reqCcr  <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd("auto ccr set", OFS_CPU_CTRL, 32'hBF);
    reqCcr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd("auto ccr clr", OFS_CPU_CTRL, 32'hB8);
    // leaving auto: level written only once auto is already off
    bus(OFS_CPU_CTRL, 1'b1, 32'hB6, 4'h1);
    rd("auto leave", OFS_CPU_CTRL, 32'hB0);
    bus(OFS_CPU_CTRL, 1'b1, 32'hB6, 4'h1);
    reqMode <= 1'b1;
    reqExt  <= 3'h5;
    repeat (3) @(posedge clk_sys);
    check("manual level", 32'(cal), 32'h6);
    // second reset in mid-run
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    reset_checks();
    repeat (2) @(posedge clk_sys);
    check("queue empty", 32'(expq.size()), 32'h0);
    stop_test();
  end
endmodule
